//--- logic/tst_channel_seq.sv
// Per-channel trigger sequencer: idle, armed, apply
`timescale 1ns/1ps
module tst_channel_seq
  import tst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Commands
  input wire logic initiate,
  input wire logic disarm,
  input wire logic imm_trig,
  input wire logic src_trig,
  // Configuration
  input wire logic volt_step_mode,
  input wire logic curr_step_mode,
  input wire logic step_trigger_out_enable,
  // Results
  output logic armed,
  output logic apply_volt,
  output logic apply_curr,
  output logic step_done,
  output logic step_trig_out
);

  tst_state_e state_q;
  logic trig_now;
  logic apply_volt_q;
  logic apply_curr_q;
  logic step_done_q;
  logic step_trig_out_q;

  assign trig_now = (state_q == ST_ARMED) && !disarm && (imm_trig || src_trig);
  assign armed = (state_q == ST_ARMED);
  assign apply_volt = apply_volt_q;
  assign apply_curr = apply_curr_q;
  assign step_done = step_done_q;
  assign step_trig_out = step_trig_out_q;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      state_q <= ST_IDLE; // see R12
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (initiate)
            state_q <= ST_ARMED; // see R13
        end
        ST_ARMED:
        begin
          // No timeout: stays armed until a trigger or a disarm
          if (disarm)
            state_q <= ST_IDLE; // see R16
          else if (imm_trig || src_trig)
            state_q <= ST_APPLY; // see R8 see R15
        end
        ST_APPLY:
          state_q <= ST_IDLE; // see R14 see R20
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Level copy strobes, high during the apply cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      apply_volt_q <= 1'b0;
      apply_curr_q <= 1'b0;
    end
    else
    begin
      // Fixed mode or no mode at all leaves the setting alone
      apply_volt_q <= trig_now && volt_step_mode; // see R2 see R4 see R5
      apply_curr_q <= trig_now && curr_step_mode; // see R2 see R4 see R5
    end
  end

  // ----------------------------------------------------------------
  // Completion and trigger out, one cycle after the copy
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      step_done_q <= 1'b0;
      step_trig_out_q <= 1'b0;
    end
    else
    begin
      step_done_q <= apply_volt_q || apply_curr_q;
      step_trig_out_q <= (apply_volt_q || apply_curr_q) && step_trigger_out_enable; // see R18 see R19
    end
  end

endmodule

//--- logic/tst_pkg.sv
// Shared constants, register map and types for the transient step trigger block
package tst_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int NUM_PINS = 8;
  localparam int LEVEL_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PIN_IDX_W = 3;
  localparam int CH_IDX_W = 2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CH_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_VSTEP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CSTEP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_VIMM = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CIMM = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_INIT_LSB = 0;
  localparam int CMD_DISARM_LSB = 4;
  localparam int CMD_IMM_LSB = 8;
  localparam int CMD_BUS_TRG_BIT = 12;
  localparam int STAT_ARMED_LSB = 0;
  localparam int STAT_STEPPED_LSB = 4;
  localparam int CFG_VMODE_BIT = 0;
  localparam int CFG_CMODE_BIT = 1;
  localparam int CFG_PORT_TRIGGER_OUTPUT_PIN_BIT = 2;
  localparam int CFG_SRC_LSB = 4;
  localparam int CFG_PIN_LSB = 8;
  localparam int CFG_CHAN_LSB = 12;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CFG_MASK = 32'h0000_3737;
  localparam logic [DATA_W-1:0] CFG_RST = 32'h0000_0000;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [LEVEL_W-1:0] tst_level_t;

  typedef enum logic [1:0] {
    SRC_BUS = 2'b00,
    SRC_PIN = 2'b01,
    SRC_CHAN = 2'b10,
    SRC_NONE = 2'b11
  } tst_src_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_APPLY = 2'b10
  } tst_state_e;

endpackage

//--- logic/tst_top.sv
// Transient step trigger block with Avalon-MM register slave
//
// Summary of operation
// R1 - Each channel can step its voltage and current settings on a trigger.
// R2 - A channel with neither function in step mode does nothing on a trigger.
// R3 - Voltage and current each have their own step or fixed mode bit.
// R4 - In step mode the step level is copied into the setting on trigger.
// R5 - In fixed mode triggers leave the setting unchanged.
// R6 - Separate voltage and current step levels are held per channel.
// R7 - Software keeps step levels inside the channel's present output range.
// R8 - An immediate trigger command fires the channel whatever source is chosen.
// R9 - With bus source, the bus device trigger command fires the channel.
// R10 - Software configures a chosen port pin as trigger input; index picks it.
// R11 - Channel source uses that channel's trigger out; software enables it there.
// R12 - After reset every channel sits idle and ignores all triggers.
// R13 - Initiate arms the addressed channels; one command may address several.
// R14 - After the step the channel returns idle; software must re-initiate.
// R15 - Pin or channel source waits with no timeout for its trigger.
// R16 - Disarm returns an armed channel to idle without applying levels.
// R17 - Each channel can emit trigger out on its step, to channels and a pin.
// R18 - A per-channel enable gates trigger out generation.
// R19 - Exactly one one-cycle trigger out pulse per completed enabled step.
// R20 - Triggers arriving while a step is being applied are ignored.
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module tst_top
  import tst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [tst_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tst_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [tst_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Digital port trigger inputs
  input wire logic [tst_pkg::NUM_PINS-1:0] port_trigger_input_pin,
  // Output settings, one field per channel
  output logic [tst_pkg::NUM_CH*tst_pkg::LEVEL_W-1:0] voltage_setting,
  output logic [tst_pkg::NUM_CH*tst_pkg::LEVEL_W-1:0] current_setting,
  // Trigger out to the digital port
  output logic [tst_pkg::NUM_CH-1:0] port_trigger_output_pin
);

  import tst_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] tst_reg_addr(input int ch, input logic [ADDR_W-1:0] ofs);
    tst_reg_addr = OFS_CH_BASE + (ADDR_W'(ch) * CH_STRIDE) + ofs;
  endfunction

  function automatic logic [DATA_W-1:0] tst_merge(input logic [DATA_W-1:0] old_val,
                                                  input logic [DATA_W-1:0] new_val,
                                                  input logic [3:0] be);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[b*8 +: 8] = new_val[b*8 +: 8];
    end
    tst_merge = res;
  endfunction

  function automatic logic tst_src_hit(input logic [DATA_W-1:0] cfg,
                                       input logic bus_trg,
                                       input logic [NUM_PINS-1:0] pin_rise,
                                       input logic [NUM_CH-1:0] touts);
    logic [PIN_IDX_W-1:0] pin;
    logic [CH_IDX_W-1:0] chn;
    logic hit;
    pin = cfg[CFG_PIN_LSB +: PIN_IDX_W];
    chn = cfg[CFG_CHAN_LSB +: CH_IDX_W];
    case (tst_src_e'(cfg[CFG_SRC_LSB +: 2]))
      SRC_BUS: hit = bus_trg; // see R9
      SRC_PIN: hit = pin_rise[pin]; // see R10
      SRC_CHAN: hit = touts[chn]; // see R11
      default: hit = 1'b0;
    endcase
    tst_src_hit = hit;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic req;
  logic wr_fire;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] cfg_q [NUM_CH];
  tst_level_t vstep_q [NUM_CH];
  tst_level_t cstep_q [NUM_CH];
  tst_level_t vimm_q [NUM_CH];
  tst_level_t cimm_q [NUM_CH];
  logic [NUM_CH-1:0] init_q;
  logic [NUM_CH-1:0] disarm_q;
  logic [NUM_CH-1:0] imm_q;
  logic bus_trg_q;
  logic [NUM_PINS-1:0] pin_prev_q;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_CH-1:0] stepped_q;
  logic [NUM_CH-1:0] trig_out_pin_q;
  logic [NUM_CH-1:0] armed;
  logic [NUM_CH-1:0] apply_volt;
  logic [NUM_CH-1:0] apply_curr;
  logic [NUM_CH-1:0] step_done;
  logic [NUM_CH-1:0] step_trig_out;
  logic [NUM_CH-1:0] src_trig;

  assign req = avs_read || avs_write;
  assign wr_fire = avs_write && !wait_q;
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign port_trigger_output_pin = trig_out_pin_q;
  assign pin_rise = port_trigger_input_pin & ~pin_prev_q;

  always_comb
  begin
    wmask = tst_merge('0, avs_writedata, avs_byteenable);
  end

  // ----------------------------------------------------------------
  // Bus handshake: one wait state, then the access completes
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      wait_q <= 1'b1;
    else if (req && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // Read data is captured in the wait cycle so it stands at the completing edge
  always_ff @(posedge clk)
  begin
    if (!rstn)
      rdata_q <= '0;
    else if (avs_read && wait_q)
      rdata_q <= rdata_d;
  end

  always_comb
  begin
    rdata_d = '0;
    if (avs_address == OFS_STATUS)
    begin
      rdata_d[STAT_ARMED_LSB +: NUM_CH] = armed;
      rdata_d[STAT_STEPPED_LSB +: NUM_CH] = stepped_q;
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (avs_address == tst_reg_addr(c, OFS_CFG))
        rdata_d = cfg_q[c];
      if (avs_address == tst_reg_addr(c, OFS_VSTEP))
        rdata_d = {16'h0000, vstep_q[c]};
      if (avs_address == tst_reg_addr(c, OFS_CSTEP))
        rdata_d = {16'h0000, cstep_q[c]};
      if (avs_address == tst_reg_addr(c, OFS_VIMM))
        rdata_d = {16'h0000, vimm_q[c]};
      if (avs_address == tst_reg_addr(c, OFS_CIMM))
        rdata_d = {16'h0000, cimm_q[c]};
    end
  end

  // ----------------------------------------------------------------
  // Command pulses, one cycle after the completing write
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      init_q <= '0;
      disarm_q <= '0;
      imm_q <= '0;
      bus_trg_q <= 1'b0;
    end
    else if (wr_fire && avs_address == OFS_CMD)
    begin
      // A single write may address any set of channels at once
      init_q <= wmask[CMD_INIT_LSB +: NUM_CH]; // see R13
      disarm_q <= wmask[CMD_DISARM_LSB +: NUM_CH]; // see R16
      imm_q <= wmask[CMD_IMM_LSB +: NUM_CH]; // see R8
      bus_trg_q <= wmask[CMD_BUS_TRG_BIT]; // see R9
    end
    else
    begin
      init_q <= '0;
      disarm_q <= '0;
      imm_q <= '0;
      bus_trg_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin edge detect: a held level fires once, not every cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pin_prev_q <= '1;
    else
      pin_prev_q <= port_trigger_input_pin;
  end

  // ----------------------------------------------------------------
  // Channel configuration and step levels
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < NUM_CH; c++)
        cfg_q[c] <= CFG_RST;
    end
    else if (wr_fire)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (avs_address == tst_reg_addr(c, OFS_CFG))
          cfg_q[c] <= tst_merge(cfg_q[c], avs_writedata, avs_byteenable) & CFG_MASK; // see R3
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        vstep_q[c] <= LEVEL_RST;
        cstep_q[c] <= LEVEL_RST;
      end
    end
    else if (wr_fire)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (avs_address == tst_reg_addr(c, OFS_VSTEP))
          vstep_q[c] <= LEVEL_W'(tst_merge({16'h0000, vstep_q[c]}, avs_writedata,
                                           avs_byteenable)); // see R6
        if (avs_address == tst_reg_addr(c, OFS_CSTEP))
          cstep_q[c] <= LEVEL_W'(tst_merge({16'h0000, cstep_q[c]}, avs_writedata,
                                           avs_byteenable)); // see R6
      end
    end
  end

  // ----------------------------------------------------------------
  // Immediate settings: a step copy takes priority over a bus write
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        vimm_q[c] <= LEVEL_RST;
        cimm_q[c] <= LEVEL_RST;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (apply_volt[c])
          vimm_q[c] <= vstep_q[c]; // see R1 see R4 see R6
        else if (wr_fire && avs_address == tst_reg_addr(c, OFS_VIMM))
          vimm_q[c] <= LEVEL_W'(tst_merge({16'h0000, vimm_q[c]}, avs_writedata,
                                          avs_byteenable));
        if (apply_curr[c])
          cimm_q[c] <= cstep_q[c]; // see R1 see R4 see R6
        else if (wr_fire && avs_address == tst_reg_addr(c, OFS_CIMM))
          cimm_q[c] <= LEVEL_W'(tst_merge({16'h0000, cimm_q[c]}, avs_writedata,
                                          avs_byteenable));
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky step flags: write one to clear, a new step wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      stepped_q <= '0;
    else if (wr_fire && avs_address == OFS_STATUS)
      stepped_q <= (stepped_q & ~wmask[STAT_STEPPED_LSB +: NUM_CH]) | step_done;
    else
      stepped_q <= stepped_q | step_done;
  end

  // ----------------------------------------------------------------
  // Trigger out to the port, delayed one cycle from the channel pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      trig_out_pin_q <= '0;
    else
      trig_out_pin_q <= step_trig_out; // see R17
  end

  // ----------------------------------------------------------------
  // Channel sequencers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    assign voltage_setting[g*LEVEL_W +: LEVEL_W] = vimm_q[g];
    assign current_setting[g*LEVEL_W +: LEVEL_W] = cimm_q[g];
    // Channel triggers come straight from the registered bus and channel pulses and the unregistered pin edge detect
    assign src_trig[g] = tst_src_hit(cfg_q[g], bus_trg_q, pin_rise, step_trig_out); // see R11 see R17

    tst_channel_seq u_seq (
      .clk(clk),
      .rstn(rstn),
      .initiate(init_q[g]),
      .disarm(disarm_q[g]),
      .imm_trig(imm_q[g]),
      .src_trig(src_trig[g]),
      .volt_step_mode(cfg_q[g][CFG_VMODE_BIT]),
      .curr_step_mode(cfg_q[g][CFG_CMODE_BIT]),
      .step_trigger_out_enable(cfg_q[g][CFG_PORT_TRIGGER_OUTPUT_PIN_BIT]),
      .armed(armed[g]),
      .apply_volt(apply_volt[g]),
      .apply_curr(apply_curr[g]),
      .step_done(step_done[g]),
      .step_trig_out(step_trig_out[g])
    );
  end

endmodule

//--- verif/tb.sv
// Self-checking bench for the transient step trigger block
`timescale 1ns/1ps
module tb;
  import tst_pkg::*;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest, fire;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, rd, cfg, trg;
  logic [3:0] trig_out;
  logic [PIN_IDX_W-1:0] pin_idx;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_CH*LEVEL_W-1:0] vset, cset;
  int errors, checks, ch, tcnt [NUM_CH];
  tst_level_t ev [NUM_CH], ec [NUM_CH];
  tst_src_e src;

  tst_top uut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_trigger_input_pin(pins), .voltage_setting(vset), .current_setting(cset),
    .port_trigger_output_pin(trig_out));
  tst_pin_host u_pins (.clk(clk), .rstn(rstn), .fire(fire), .pin_idx(pin_idx),
    .port_trigger_input_pin(pins));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      tcnt[i] += int'(trig_out[i] === 1'b1);
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // About 17 shots of under 200 cycles each; ample margin over that
  initial
  begin
    #300us;
    errors++;
    $display("watchdog expired");
    end_sim();
  end

  task automatic chk(input string name, input logic [DATA_W-1:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never completes
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic [ADDR_W-1:0] cha(input int c);
    return OFS_CH_BASE + CH_STRIDE * ADDR_W'(c);
  endfunction

  function automatic logic [DATA_W-1:0] cfgw(input logic vm, cm, to, input logic [1:0] s,
                                             input logic [2:0] pin, input logic [1:0] sc);
    return {18'h0, sc, 1'b0, pin, 2'h0, s, 1'b0, to, cm, vm};
  endfunction

  function automatic tst_level_t nxt(input logic step, go, input tst_level_t old, lvl);
    return (step && go) ? lvl : old;
  endfunction

  // Program a channel, optionally arm and disarm it, trigger it and compare the outcome
  task automatic shot(input int c, input logic [DATA_W-1:0] cf, input logic arm, dis, fires,
                      input logic [DATA_W-1:0] tg);
    tst_level_t v, k;
    logic go;
    v = tst_level_t'($urandom);
    k = tst_level_t'($urandom);
    go = arm && !dis && fires;
    tcnt = '{default: 0};
    bus(1'b1, cha(c) + OFS_CFG, cf);
    bus(1'b1, cha(c) + OFS_VSTEP, {16'h0, v});
    bus(1'b1, cha(c) + OFS_CSTEP, {16'h0, k});
    if (arm)
    begin
      bus(1'b1, OFS_CMD, 32'h1 << c);
    end
    if (dis)
    begin
      bus(1'b1, OFS_CMD, 32'h10 << c);
    end
    bus(1'b1, OFS_STATUS, 32'hf0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("armed", rd[c], arm && !dis);
    if (tg == 32'h0)
    begin
      repeat (40) @(posedge clk);
      fire <= 1'b1;
      pin_idx <= cf[10:8];
      @(posedge clk);
      fire <= 1'b0;
    end
    else
    begin
      bus(1'b1, OFS_CMD, tg);
    end
    repeat (12) @(posedge clk);
    ev[c] = nxt(cf[0], go, ev[c], v);
    ec[c] = nxt(cf[1], go, ec[c], k);
    chk("voltage", vset[c*LEVEL_W +: LEVEL_W], ev[c]);
    chk("current", cset[c*LEVEL_W +: LEVEL_W], ec[c]);
    chk("trig out count", tcnt[c], go && cf[2] && cf[1:0] != 2'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("armed after", rd[c], arm && !dis && !fires);
    chk("stepped", rd[4 + c], go && cf[1:0] != 2'h0);
  endtask

  initial
  begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    fire = 1'b0;
    pin_idx = '0;
    void'($urandom(32'h0329ee9d));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < NUM_CH; i++)
    begin
      bus(1'b0, cha(i), 32'h0);
      chk("cfg reset", rd, CFG_RST);
      chk("vset reset", vset[i*LEVEL_W +: LEVEL_W], LEVEL_RST);
      ev[i] = LEVEL_RST;
      bus(1'b1, cha(i) + OFS_CIMM, 32'h0077);
      ec[i] = 16'h0077;
    end
    bus(1'b1, 8'hc0, 32'hffff_ffff);
    bus(1'b0, 8'hc0, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      ch = $urandom_range(NUM_CH - 1);
      src = tst_src_e'(i % 4);
      cfg = cfgw(i[2], i[3], 1'($urandom), src, 3'($urandom), 2'((ch + 1) % NUM_CH));
      trg = src == SRC_PIN ? 32'h0 : ((src == SRC_CHAN || i[2]) ? 32'h100 << ch : 32'h1000);
      shot(ch, cfg, i % 5 != 3, i % 6 == 5, src == SRC_BUS || trg != 32'h1000, trg);
    end
    $display("test random shots done");
    bus(1'b1, cha(1), cfgw(1'b1, 1'b1, 1'b0, SRC_CHAN, 3'h0, 2'h0));
    bus(1'b1, cha(1) + OFS_VSTEP, 32'h1234);
    bus(1'b1, cha(1) + OFS_CSTEP, 32'h0567);
    bus(1'b1, OFS_CMD, 32'h3);
    shot(0, cfgw(1'b1, 1'b1, 1'b1, SRC_BUS, 3'h0, 2'h0), 1'b1, 1'b0, 1'b1, 32'h100);
    chk("listener voltage", vset[LEVEL_W +: LEVEL_W], 16'h1234);
    chk("listener current", cset[LEVEL_W +: LEVEL_W], 16'h0567);
    chk("listener trig out", tcnt[1], 0);
    $display("test channel source done");
    end_sim();
  end
endmodule

//--- verif/tst_pin_host.sv
// Host side model driving the digital port trigger inputs
`timescale 1ns/1ps
module tst_pin_host
  import tst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request from the bench
  input wire logic fire,
  input wire logic [tst_pkg::PIN_IDX_W-1:0] pin_idx,
  // Pins, pulled low at rest
  output logic [tst_pkg::NUM_PINS-1:0] port_trigger_input_pin
);
  logic [1:0] hold_q;
  // A pin held two cycles gives the receiver one clean rising edge
  always_ff @(posedge clk)
  begin
    if (!rstn || hold_q == 2'h1)
    begin
      port_trigger_input_pin <= 8'h00;
    end
    else if (fire)
    begin
      port_trigger_input_pin <= 8'h01 << pin_idx;
    end
    hold_q <= !rstn ? 2'h0 : (fire ? 2'h2 : hold_q - {1'b0, hold_q != 2'h0});
  end
endmodule

//--- verif/tst_top_props.sv
// Port-level assertion checker for the transient step trigger block
`timescale 1ns/1ps
module tst_top_props
  import tst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire logic [tst_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tst_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and settings
  input wire logic [tst_pkg::NUM_PINS-1:0] port_trigger_input_pin,
  input wire logic [tst_pkg::NUM_CH*tst_pkg::LEVEL_W-1:0] voltage_setting,
  input wire logic [tst_pkg::NUM_CH*tst_pkg::LEVEL_W-1:0] current_setting,
  input wire logic [tst_pkg::NUM_CH-1:0] port_trigger_output_pin
);
  logic [4:0] quiet_q;
  logic [7:0] pin_q;
  logic cause;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since the last possible cause of a step; a chain of four channels stays under 16
  assign cause = !rstn || (avs_write && !avs_waitrequest) || |(port_trigger_input_pin & ~pin_q);
  always_ff @(posedge clk)
  begin
    pin_q <= port_trigger_input_pin;
    quiet_q <= cause ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1f};
  end
  property p_wait_one;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered");
  property p_wait_idle;
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low when idle");
  property p_trig_out_pulse;
    (port_trigger_output_pin & $past(port_trigger_output_pin)) == 4'h0;
  endproperty
  a_trig_out_pulse: assert property (p_trig_out_pulse) else $error("trigger out too wide");
  property p_set_cause;
    $changed(voltage_setting) || $changed(current_setting) |-> quiet_q <= 5'h10;
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("setting moved without cause");
  property p_trig_out_cause;
    |port_trigger_output_pin |-> quiet_q <= 5'h10;
  endproperty
  a_trig_out_cause: assert property (p_trig_out_cause) else $error("trigger out without cause");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address >= 8'ha0 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cfg_resv;
    avs_read && !avs_waitrequest && avs_address[4:0] == 5'h00 && avs_address[7:5] != 3'h0
      && avs_address < 8'ha0 |-> (avs_readdata & ~CFG_MASK) == 32'h0;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv) else $error("config reserved bits set");
  c_trig_out: cover property ($rose(|port_trigger_output_pin));
  c_cmd: cover property (avs_write && !avs_waitrequest && avs_address == OFS_CMD);
  c_step: cover property ($changed(voltage_setting));
endmodule
bind tst_top tst_top_props u_props (.clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .port_trigger_input_pin(port_trigger_input_pin),
  .voltage_setting(voltage_setting), .current_setting(current_setting),
  .port_trigger_output_pin(port_trigger_output_pin));
